// ### odcb_regs.vh
// register indices, field positions and reset values of the output driver configuration bank
// assumes: included by the bank; byte address = index * 4 on a 32-bit bus
`ifndef ODCB_REGS_VH
`define ODCB_REGS_VH

`define ODCB_IDX_W          8
`define ODCB_IDX_MODE       8'h16
`define ODCB_IDX_EDGE       8'h1A
`define ODCB_IDX_LEVEL      8'h1B
`define ODCB_IDX_TIMING     8'h1C
`define ODCB_IDX_SOURCE     8'h1D
`define ODCB_IDX_OVERCUR    8'h1E
`define ODCB_IDX_OPENLOAD   8'h1F
`define ODCB_IDX_STATUS     8'h40

`define ODCB_RST_MODE       16'h0000
`define ODCB_RST_EDGE       16'h0000
`define ODCB_RST_LEVEL      16'h0000
`define ODCB_RST_TIMING     16'h0000
`define ODCB_RST_SOURCE     16'h0000
`define ODCB_RST_OVERCUR    16'h1000
`define ODCB_RST_OPENLOAD   16'h0000

`define ODCB_MODE_B1        6
`define ODCB_MODE_B2        7
`define ODCB_CHOP_EN_LSB    10
`define ODCB_LVL_B1         0
`define ODCB_LVL_B2         1
`define ODCB_LVL_B3_LSB     2
`define ODCB_OFFT_LSB       12
`define ODCB_HEAT_LSB       14
`define ODCB_GLASS_BIT      12
`define ODCB_OC_LSB         1
`define ODCB_RES7_BIT       0
`define ODCB_OL_LSB         9

`define ODCB_SRC_OFF        2'h0
`define ODCB_SRC_REG        2'h1
`define ODCB_SRC_PIN        2'h2
`define ODCB_SRC_GEN        2'h3
`define ODCB_CODE_RSVD      2'h3
`define ODCB_HS11_POS       4

`define ODCB_NREG           7
`define ODCB_HTRANS_NONSEQ  1

`endif

// ### odcb_bank.v
// output driver configuration bank: 16-bit config registers behind an AHB-Lite slave
// assumes: one clock, single word transfers, the one slave on the bus
//
// Notes on behaviour
// - two-bit edge rate per half-bridge
// - chop enable bits 15..10, regulate only when set
// - bridge pairs share one chop level output
// - bridge six level codes, 11 reserved
// - bridge five level codes, 11 reserved
// - bridges three, four level codes, 11 reserved
// - bridges one, two single-bit level
// - chop timing shared per bridge pair; the bank keeps a two-bit chop rate per bridge instead
// - common two-bit off-time select, 00 disables
// - chop rate field sets period for off-time
// - in pwm mode rate field sets pwm rate
// - heater source: off, register, pin one
// - high-side source: off, register, pin, generator
// - glass supply bit 12 resets one
// - overcurrent level bit per driver 8..12
// - bit 0 selects driver seven resistance
// - openload level bits 9..13
// - bridge one/two high-side pwm mode bits
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/10ps
`include "odcb_regs.vh"

module odcb_bank #(
    parameter ADDR_W = 10
) (
    input  wire              hclk,
    input  wire              hresetn,
    input  wire              hsel,
    input  wire [ADDR_W-1:0] haddr,
    input  wire [1:0]        htrans,
    input  wire              hwrite,
    input  wire [2:0]        hsize,
    input  wire [31:0]       hwdata,
    input  wire              hready,
    output wire [31:0]       hrdata,
    output wire              hreadyout,
    output wire              hresp,
    output wire [11:0]       bridge_edge_rate,
    output wire [5:0]        bridge_chop_on,
    output wire [5:0]        bridge_chop_active,
    output wire [3:0]        pair12_chop_level,
    output wire [3:0]        pair34_chop_level,
    output wire [3:0]        pair56_chop_level,
    output wire [3:0]        bridge_level_reserved,
    output wire [11:0]       bridge_chop_rate,
    output wire [1:0]        bridge_off_time_select,
    output wire              bridge_off_time_on,
    output wire [1:0]        bridge_highside_pwm_mode,
    output wire [1:0]        bridge1_internal_pwm_rate,
    output wire [1:0]        bridge2_internal_pwm_rate,
    output wire [1:0]        heater_source_select,
    output wire              heater_by_register,
    output wire              heater_by_pin,
    output wire [11:0]       hs_source_select,
    output wire [5:0]        hs_by_register,
    output wire [5:0]        hs_by_pin,
    output wire [5:0]        hs_by_generator,
    output wire              hs11_glass_supply_mode,
    output wire [4:0]        hs_overcurrent_level,
    output wire              hs7_resistance_mode,
    output wire [4:0]        hs_openload_level
);

    localparam IW = `ODCB_IDX_W;

    function [IW-1:0] reg_idx;
        input integer k;
        begin
            case (k)
                0:       reg_idx = `ODCB_IDX_MODE;
                1:       reg_idx = `ODCB_IDX_EDGE;
                2:       reg_idx = `ODCB_IDX_LEVEL;
                3:       reg_idx = `ODCB_IDX_TIMING;
                4:       reg_idx = `ODCB_IDX_SOURCE;
                5:       reg_idx = `ODCB_IDX_OVERCUR;
                default: reg_idx = `ODCB_IDX_OPENLOAD;
            endcase
        end
    endfunction

    function [15:0] reg_rst;
        input integer k;
        begin
            case (k)
                0:       reg_rst = `ODCB_RST_MODE;
                1:       reg_rst = `ODCB_RST_EDGE;
                2:       reg_rst = `ODCB_RST_LEVEL;
                3:       reg_rst = `ODCB_RST_TIMING;
                4:       reg_rst = `ODCB_RST_SOURCE;
                5:       reg_rst = `ODCB_RST_OVERCUR;
                default: reg_rst = `ODCB_RST_OPENLOAD;
            endcase
        end
    endfunction

    wire [15:0]   cfg [0:`ODCB_NREG-1];
    reg           wr_pend_ff;
    reg  [IW-1:0] wr_idx_ff;
    reg  [15:0]   rdata_ff;
    reg  [15:0]   nxt_rdata;
    wire          taken;
    wire          aligned;
    wire [IW-1:0] req_idx;
    wire [15:0]   status;

    // zero-wait slave, never an error
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = {16'h0000, rdata_ff};

    assign taken   = hsel & hready & htrans[`ODCB_HTRANS_NONSEQ];
    assign aligned = (haddr[1:0] == 2'h0) & (haddr[ADDR_W-1:2] < (1 << IW));
    assign req_idx = haddr[IW+1:2];

    // write data arrives one cycle after the address is taken
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff  <= {IW{1'b0}};
        end
        else
        begin
            wr_pend_ff <= taken & hwrite & aligned;
            wr_idx_ff  <= req_idx;
        end
    end

    // full 16 bits kept, reserved positions included
    genvar k;
    generate
        for (k = 0; k < `ODCB_NREG; k = k + 1)
        begin : g_cfg
            reg [15:0] cfg_ff;
            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    cfg_ff <= reg_rst(k);
                else if (wr_pend_ff && (wr_idx_ff == reg_idx(k)))
                    cfg_ff <= hwdata[15:0];
            end
            assign cfg[k] = cfg_ff;
        end
    endgenerate

    // read sampled at the address edge; a write still in its data phase is
    // forwarded so back-to-back write then read returns the new value
    integer i;
    always @*
    begin
        nxt_rdata = 16'h0000;
        for (i = 0; i < `ODCB_NREG; i = i + 1)
        begin
            if (req_idx == reg_idx(i))
            begin
                if (wr_pend_ff && (wr_idx_ff == req_idx))
                    nxt_rdata = hwdata[15:0];
                else
                    nxt_rdata = cfg[i];
            end
        end
        if (req_idx == `ODCB_IDX_STATUS)
            nxt_rdata = status;
        if (!aligned)
            nxt_rdata = 16'h0000;
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_ff <= 16'h0000;
        else if (taken && !hwrite)
            rdata_ff <= nxt_rdata;
    end

    // half-bridge edge rate
    assign bridge_edge_rate = cfg[1][11:0];

    // bridge one/two high-side pwm mode
    assign bridge_highside_pwm_mode = {cfg[0][`ODCB_MODE_B2], cfg[0][`ODCB_MODE_B1]};

    // chop regulation enables; a bridge in high-side pwm mode does not regulate
    assign bridge_chop_on     = cfg[2][`ODCB_CHOP_EN_LSB+5:`ODCB_CHOP_EN_LSB];
    assign bridge_chop_active = bridge_chop_on & {4'hF, ~bridge_highside_pwm_mode};

    // levels handed out per pair, lower bridge in the low half
    assign pair12_chop_level = {1'b0, cfg[2][`ODCB_LVL_B2], 1'b0, cfg[2][`ODCB_LVL_B1]};
    assign pair34_chop_level = cfg[2][`ODCB_LVL_B3_LSB+3:`ODCB_LVL_B3_LSB];
    assign pair56_chop_level = cfg[2][`ODCB_LVL_B3_LSB+7:`ODCB_LVL_B3_LSB+4];

    // reserved level code flags, bit 0 for bridge three up to bit 3 for six
    generate
        for (k = 0; k < 4; k = k + 1)
        begin : g_lvl_rsvd
            assign bridge_level_reserved[k] =
                (cfg[2][`ODCB_LVL_B3_LSB+2*k+1:`ODCB_LVL_B3_LSB+2*k] == `ODCB_CODE_RSVD);
        end
    endgenerate

    // chop rate per bridge, pairs program alike
    assign bridge_chop_rate = cfg[3][11:0];

    // off-time as fraction of the chop period
    assign bridge_off_time_select = cfg[3][`ODCB_OFFT_LSB+1:`ODCB_OFFT_LSB];
    assign bridge_off_time_on     = (bridge_off_time_select != 2'h0);

    // in high-side pwm mode the rate field means pwm rate; zero otherwise
    assign bridge1_internal_pwm_rate = bridge_highside_pwm_mode[0] ? cfg[3][1:0] : 2'h0;
    assign bridge2_internal_pwm_rate = bridge_highside_pwm_mode[1] ? cfg[3][3:2] : 2'h0;

    // heater source, reserved code acts as disabled
    assign heater_source_select = cfg[4][`ODCB_HEAT_LSB+1:`ODCB_HEAT_LSB];
    assign heater_by_register   = (heater_source_select == `ODCB_SRC_REG);
    assign heater_by_pin        = (heater_source_select == `ODCB_SRC_PIN);

    // glass supply mode takes driver eleven away from its own selector
    assign hs11_glass_supply_mode = cfg[5][`ODCB_GLASS_BIT];
    assign hs_source_select       = cfg[4][11:0];

    generate
        for (k = 0; k < 6; k = k + 1)
        begin : g_hs
            wire [1:0] src;
            wire       own;
            assign own = (k != `ODCB_HS11_POS) | ~hs11_glass_supply_mode;
            assign src = hs_source_select[2*k+1:2*k];
            assign hs_by_register[k]  = own & (src == `ODCB_SRC_REG);
            assign hs_by_pin[k]       = own & (src == `ODCB_SRC_PIN);
            assign hs_by_generator[k] = own & (src == `ODCB_SRC_GEN);
        end
    endgenerate

    // high-side thresholds
    assign hs_overcurrent_level = cfg[5][`ODCB_OC_LSB+4:`ODCB_OC_LSB];
    assign hs7_resistance_mode  = cfg[5][`ODCB_RES7_BIT];
    assign hs_openload_level    = cfg[6][`ODCB_OL_LSB+4:`ODCB_OL_LSB];

    // read-only view of the decoded state
    assign status = {bridge_off_time_on,
                     hs11_glass_supply_mode,
                     hs_by_generator,
                     bridge_level_reserved,
                     bridge_chop_active[1:0],
                     heater_by_register | heater_by_pin,
                     1'b0};

endmodule // odcb_bank

// ### odcb_bank_checker.sv
// checker: bus answers and derived config outputs of the configuration bank
// assumes: bound into odcb_bank, one clock, zero-wait slave
`timescale 1ns/10ps
module odcb_checker #(
    parameter ADDR_W = 10
) (
    input wire              hclk,
    input wire              hresetn,
    input wire              hsel,
    input wire              hwrite,
    input wire              hready,
    input wire              hreadyout,
    input wire              hresp,
    input wire [ADDR_W-1:0] haddr,
    input wire [1:0]        htrans,
    input wire [1:0]        bridge_highside_pwm_mode,
    input wire [1:0]        bridge_off_time_select,
    input wire [1:0]        heater_source_select,
    input wire [31:0]       hrdata,
    input wire [5:0]        bridge_chop_on,
    input wire [5:0]        bridge_chop_active,
    input wire [5:0]        hs_by_register,
    input wire [5:0]        hs_by_pin,
    input wire [5:0]        hs_by_generator,
    input wire              bridge_off_time_on,
    input wire              heater_by_register,
    input wire              heater_by_pin,
    input wire              hs11_glass_supply_mode,
    input wire [11:0]       hs_source_select
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_take; hsel && hready && htrans[1]; endsequence
    sequence s_read; s_take ##0 !hwrite; endsequence
    property p_okay; hreadyout && !hresp; endproperty
    a_okay: assert property (p_okay) else $error("bus not ready or not okay");
    // a write lands one edge after its address phase, so look two edges on
    property p_hold; !(hsel && hready && htrans[1] && hwrite) |-> ##2 $stable(bridge_chop_on); endproperty
    a_hold: assert property (p_hold) else $error("chop enables changed without a write");
    property p_unmapped; s_read ##0 (haddr[1:0] != 2'h0) |=> hrdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("misaligned read not zero");
    property p_upper; s_read |=> hrdata[31:16] == 16'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read half not zero");
    property p_chop_act; bridge_chop_active == (bridge_chop_on & ~{4'h0, bridge_highside_pwm_mode}); endproperty
    a_chop_act: assert property (p_chop_act) else $error("chop active mismatch");
    property p_toff; bridge_off_time_on == (bridge_off_time_select != 2'h0); endproperty
    a_toff: assert property (p_toff) else $error("off time enable mismatch");
    property p_heat;
        heater_by_register == (heater_source_select == 2'h1) && heater_by_pin == (heater_source_select == 2'h2);
    endproperty
    a_heat: assert property (p_heat) else $error("heater source decode mismatch");
    property p_hs_src;
        hs_by_generator[0] == (hs_source_select[1:0] == 2'h3) && hs_by_pin[0] == (hs_source_select[1:0] == 2'h2);
    endproperty
    a_hs_src: assert property (p_hs_src) else $error("driver seven source decode mismatch");
    property p_glass; hs11_glass_supply_mode |-> !hs_by_register[4] && !hs_by_pin[4] && !hs_by_generator[4]; endproperty
    a_glass: assert property (p_glass) else $error("driver eleven active in glass mode");
endmodule // odcb_checker

bind odcb_bank odcb_checker #(.ADDR_W(ADDR_W)) u_chk (.hclk, .hresetn, .hsel, .hwrite, .hready, .hreadyout, .hresp,
    .haddr, .htrans, .bridge_highside_pwm_mode, .bridge_off_time_select, .heater_source_select, .hrdata,
    .bridge_chop_on, .bridge_chop_active, .hs_by_register, .hs_by_pin, .hs_by_generator, .bridge_off_time_on,
    .heater_by_register, .heater_by_pin, .hs11_glass_supply_mode, .hs_source_select);

// ### odcb_tb.sv
// testbench: register access over AHB-Lite and decoded config outputs of the bank
// assumes: odcb_bank is the one slave, hready looped back from hreadyout
`timescale 1ns/10ps
`include "odcb_regs.vh"
module testbench;
    logic        hclk, hresetn, hsel, hwrite;
    logic [9:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, rd;
    logic [15:0] v;
    wire  [31:0] hrdata;
    wire         hready, hresp, bridge_off_time_on, heater_by_register, heater_by_pin;
    wire         hs11_glass_supply_mode, hs7_resistance_mode;
    wire  [11:0] bridge_edge_rate, bridge_chop_rate, hs_source_select;
    wire  [5:0]  bridge_chop_on, bridge_chop_active, hs_by_register, hs_by_pin, hs_by_generator;
    wire  [4:0]  hs_overcurrent_level, hs_openload_level;
    wire  [3:0]  pair12_chop_level, pair34_chop_level, pair56_chop_level, bridge_level_reserved;
    wire  [1:0]  bridge_off_time_select, bridge_highside_pwm_mode, heater_source_select;
    wire  [1:0]  bridge1_internal_pwm_rate, bridge2_internal_pwm_rate;
    int          n_mismatch = 0, tests_run = 0, cyc = 0;
    logic [9:0]  ra [7] = '{10'h58, 10'h68, 10'h6C, 10'h70, 10'h74, 10'h78, 10'h7C};
    logic [15:0] rv [7] = '{`ODCB_RST_MODE, `ODCB_RST_EDGE, `ODCB_RST_LEVEL, `ODCB_RST_TIMING,
                            `ODCB_RST_SOURCE, 16'h1000, `ODCB_RST_OPENLOAD};

    odcb_bank #(.ADDR_W(10)) i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout(hready), .hresp, .bridge_edge_rate, .bridge_chop_on, .bridge_chop_active,
        .pair12_chop_level, .pair34_chop_level, .pair56_chop_level, .bridge_level_reserved, .bridge_chop_rate,
        .bridge_off_time_select, .bridge_off_time_on, .bridge_highside_pwm_mode, .bridge1_internal_pwm_rate,
        .bridge2_internal_pwm_rate, .heater_source_select, .heater_by_register, .heater_by_pin, .hs_source_select,
        .hs_by_register, .hs_by_pin, .hs_by_generator, .hs11_glass_supply_mode, .hs_overcurrent_level,
        .hs7_resistance_mode, .hs_openload_level);

    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    task automatic conclude;
        if (n_mismatch == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // hang guard: the whole sequence needs about 120 cycles
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // entered just after an edge; address phase, then data phase
    task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    // extra edge so the decoded outputs have settled before checking
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        @(posedge hclk);
    endtask

    task automatic rdc(input logic [9:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk("rdata", e, rd);
    endtask

    initial
    begin
        hresetn = 1'b0;
        hsel    = 1'b0;
        haddr   = 10'h0;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        hwdata  = 32'h0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 7; i++) rdc(ra[i], {16'h0, rv[i]});
        chk("glass", 'h1, 32'(hs11_glass_supply_mode));
        for (int i = 0; i < 7; i++)
        begin
            xfer(1'b1, ra[i], 32'hFFFF_A5C3 ^ i);
            rdc(ra[i], 32'h0000_A5C3 ^ i);
        end
        wr(10'h58, 'h0040);
        wr(10'h68, 'h0924);
        chk("edge", 'h924, 32'(bridge_edge_rate));
        wr(10'h6C, 'hFF9E);
        chk("chop_on", 'h3F, 32'(bridge_chop_on));
        chk("pair12", 'h4, 32'(pair12_chop_level));
        chk("pair34", 'h7, 32'(pair34_chop_level));
        chk("pair56", 'hE, 32'(pair56_chop_level));
        chk("lvl_rsvd", 'h9, 32'(bridge_level_reserved));
        wr(10'h70, 'h1E4B);
        chk("rate", 'hE4B, 32'(bridge_chop_rate));
        chk("toff", 'h1, 32'(bridge_off_time_select));
        chk("pwm1", 'h3, 32'(bridge1_internal_pwm_rate));
        chk("pwm2", 'h0, 32'(bridge2_internal_pwm_rate));
        chk("active", 'h3E, 32'(bridge_chop_active));
        wr(10'h58, 'h00C0);
        chk("pwm_mode", 'h3, 32'(bridge_highside_pwm_mode));
        chk("pwm2", 'h2, 32'(bridge2_internal_pwm_rate));
        chk("active", 'h3C, 32'(bridge_chop_active));
        // glass mode on, so driver eleven stays masked through the loop
        wr(10'h78, 'h1000);
        chk("glass_on", 'h1, 32'(hs11_glass_supply_mode));
        for (int c = 0; c < 4; c++)
        begin
            wr(10'h70, c << 12);
            chk("toff_on", 32'(c != 0), 32'(bridge_off_time_on));
            v = {c[1:0], 2'b00, {6{c[1:0]}}};
            wr(10'h74, {16'h0, v});
            chk("heat_src", 32'(c), 32'(heater_source_select));
            chk("hs_src", 32'({6{c[1:0]}}), 32'(hs_source_select));
            chk("heat_reg", 32'(c == 1), 32'(heater_by_register));
            chk("heat_pin", 32'(c == 2), 32'(heater_by_pin));
            chk("hs_reg", (c == 1) ? 'h2F : 'h0, 32'(hs_by_register));
            chk("hs_pin", (c == 2) ? 'h2F : 'h0, 32'(hs_by_pin));
            chk("hs_gen", (c == 3) ? 'h2F : 'h0, 32'(hs_by_generator));
        end
        wr(10'h78, 'h002B);
        chk("oc", 'h15, 32'(hs_overcurrent_level));
        chk("rdson", 'h1, 32'(hs7_resistance_mode));
        chk("hs_gen", 'h3F, 32'(hs_by_generator));
        wr(10'h7C, 'h3400);
        chk("ol", 'h1A, 32'(hs_openload_level));
        rdc(10'h100, 'hBF90);
        xfer(1'b1, 10'h60, 'hFFFF);
        rdc(10'h60, 'h0);
        rdc(10'h6E, 'h0);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(10'h78, 'h1000);
        rdc(10'h6C, 'h0);
        conclude();
    end
endmodule // testbench
